// ---- verilog/dfso_top.sv ----
// status output selector for one multifunction output terminal
// assumes all inputs synchronous to mclk, frequencies as magnitudes
`timescale 1ns/100ps
module dfso_top (
    input  logic                 mclk,                   // 100 MHz clock
    input  logic                 rst_n,                  // sync reset
    input  dfso_pkg::dfso_fsel_t output_function_select, // function code
    input  logic [1:0]           control_method_select,  // 0 v/f, 2 vector
    input  logic                 run_cmd,                // run command
    input  logic                 volt_out,               // output active
    input  dfso_pkg::dfso_freq_t out_freq,               // freq magnitude
    input  dfso_pkg::dfso_freq_t freq_ref,               // ref magnitude
    input  dfso_pkg::dfso_freq_t minimum_output_frequency, // v/f thr
    input  dfso_pkg::dfso_freq_t zero_speed_threshold,   // vector thr
    input  dfso_pkg::dfso_freq_t speed_agree_level,      // detect level
    input  dfso_pkg::dfso_freq_t speed_agree_width,      // agree width
    input  logic                 detection_during_stop_select, // 1 always
    output logic                 multifunction_output    // terminal
);
    import dfso_pkg::*;

    dfso_cmp_if cmp ();
    dfso_freq_t zthr;
    dfso_fsel_t base;
    logic       inv;
    logic       det_en;
    logic       det1_reg, det1_next;
    logic       det2_reg, det2_next;
    logic       out_reg, out_next;
    logic       func;

    // zero-speed threshold by control method
    always_comb
    begin
        zthr = (control_method_select == CM_VECTOR) ? zero_speed_threshold
                                                    : minimum_output_frequency;
    end

    dfso_cmp u_cmp (
        .freq (out_freq),
        .fref (freq_ref),
        .zthr (zthr),
        .lvl  (speed_agree_level),
        .wid  (speed_agree_width),
        .cmp  (cmp)
    );

    // inverse codes strip the leading 1
    always_comb
    begin
        inv  = (output_function_select >= FN_INV_BASE) &&
               (output_function_select <= FN_INV_TOP);
        base = inv ? output_function_select - FN_INV_BASE
                   : output_function_select;
        det_en = detection_during_stop_select || volt_out;
    end

    // falling detector latch: opens above level plus width and closes only
    // once frequency is back at the level, so a frequency wobbling inside
    // the band cannot make the terminal chatter
    always_comb
    begin
        det1_next = det1_reg;
        if (cmp.above_hi)
            det1_next = 1'b0;
        else if (cmp.at_or_below)
            det1_next = 1'b1;
    end

    // falling detector register, set in reset as a standing drive is
    // below any level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            det1_reg <= RST_DET1;
        else
            det1_reg <= det1_next;
    end

    // rising detector latch: sets above the level and holds until the
    // frequency is down to level minus width; the clear bound never lies
    // above the set bound, so set and clear cannot fall in one cycle
    always_comb
    begin
        det2_next = det2_reg;
        if (cmp.above_lvl)
            det2_next = 1'b1;
        else if (cmp.at_or_lo)
            det2_next = 1'b0;
    end

    // rising detector register, clear in reset
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            det2_reg <= RST_DET2;
        else
            det2_reg <= det2_next;
    end

    // selected function
    always_comb
    begin
        case (base)
            FN_RUN:   func = run_cmd || volt_out;
            FN_ZERO:  func = cmp.below_zero;
            FN_AGREE: func = cmp.in_ref;
            FN_USER:  func = cmp.in_ref && cmp.in_lvl;
            FN_DET1:  func = det1_reg && det_en;
            FN_DET2:  func = det2_reg && det_en;
            default:  func = 1'b0;
        endcase
        out_next = func ^ inv;
    end

    // terminal register; the pin comes straight from this flop so the far
    // side never sees the decode settle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            out_reg <= RST_OUT;
        else
            out_reg <= out_next;
    end

    assign multifunction_output = out_reg;
endmodule : dfso_top

// ---- verilog/dfso_pkg.sv ----
// constants and types for the drive frequency status output block
// assumes one system clock and frequencies as unsigned magnitudes
package dfso_pkg;
    localparam int FREQ_W = 16;
    localparam int FSEL_W = 12;
    typedef logic [FREQ_W-1:0] dfso_freq_t;
    typedef logic [FSEL_W-1:0] dfso_fsel_t;
    // function codes, hex-coded like the setting values
    localparam dfso_fsel_t FN_RUN      = 12'h000;
    localparam dfso_fsel_t FN_ZERO     = 12'h001;
    localparam dfso_fsel_t FN_AGREE    = 12'h002;
    localparam dfso_fsel_t FN_USER     = 12'h003;
    localparam dfso_fsel_t FN_DET1     = 12'h004;
    localparam dfso_fsel_t FN_DET2     = 12'h005;
    localparam dfso_fsel_t FN_INV_BASE = 12'h100;
    localparam dfso_fsel_t FN_INV_TOP  = 12'h158;
    localparam logic [1:0] CM_VF     = 2'h0;
    localparam logic [1:0] CM_VECTOR = 2'h2;
    // reset values
    localparam logic RST_OUT  = 1'b0;
    localparam logic RST_DET1 = 1'b1;
    localparam logic RST_DET2 = 1'b0;
endpackage : dfso_pkg

// ---- verilog/dfso_cmp_if.sv ----
// comparison results passed from the comparator unit to the top
// assumes both ends share mclk
`timescale 1ns/100ps
interface dfso_cmp_if;
    logic below_zero;  // frequency under zero-speed threshold
    logic in_ref;      // within reference band
    logic in_lvl;      // within detection level band
    logic above_hi;    // above level plus width
    logic at_or_below; // at or below level
    logic above_lvl;   // above level
    logic at_or_lo;    // at or below level minus width
    modport src (output below_zero, in_ref, in_lvl, above_hi,
                 at_or_below, above_lvl, at_or_lo);
    modport dst (input below_zero, in_ref, in_lvl, above_hi,
                 at_or_below, above_lvl, at_or_lo);
endinterface : dfso_cmp_if

// ---- verilog/dfso_cmp.sv ----
// magnitude comparators for the status output block
// assumes inputs already synchronous to mclk
`timescale 1ns/100ps
module dfso_cmp (
    input  dfso_pkg::dfso_freq_t freq,      // output frequency magnitude
    input  dfso_pkg::dfso_freq_t fref,      // reference magnitude
    input  dfso_pkg::dfso_freq_t zthr,      // chosen zero-speed threshold
    input  dfso_pkg::dfso_freq_t lvl,       // detection level
    input  dfso_pkg::dfso_freq_t wid,       // agree width
    dfso_cmp_if.src              cmp        // comparison results
);
    import dfso_pkg::*;

    logic [FREQ_W:0] ref_lo, ref_hi, lvl_lo, lvl_hi, f;
    // widened bands so sums never wrap, lower bounds floor at zero
    always_comb
    begin
        f      = {1'b0, freq};
        ref_hi = {1'b0, fref} + {1'b0, wid};
        lvl_hi = {1'b0, lvl} + {1'b0, wid};
        ref_lo = (fref > wid) ? {1'b0, fref} - {1'b0, wid} : '0;
        lvl_lo = (lvl > wid) ? {1'b0, lvl} - {1'b0, wid} : '0;
    end
    // magnitudes only, so direction does not matter
    assign cmp.below_zero  = freq < zthr;
    assign cmp.in_ref      = (f >= ref_lo) && (f <= ref_hi);
    assign cmp.in_lvl      = (f >= lvl_lo) && (f <= lvl_hi);
    assign cmp.above_hi    = f > lvl_hi;
    assign cmp.at_or_below = freq <= lvl;
    assign cmp.above_lvl   = freq > lvl;
    assign cmp.at_or_lo    = f <= lvl_lo;
endmodule : dfso_cmp

// ---- tb/dfso_top_properties.sv ----
// checker for the status output terminal
// assumes bind to dfso_top, one clock, sync reset
`timescale 1ns/100ps
module dfso_top_properties (
    input logic mclk, rst_n, run_cmd, volt_out, // clock, reset, run
    input logic detection_during_stop_select,   // detect always
    input logic [1:0] control_method_select,    // method
    input logic multifunction_output,           // terminal
    input dfso_pkg::dfso_fsel_t output_function_select, // code
    input dfso_pkg::dfso_freq_t out_freq, freq_ref, speed_agree_level,
    input dfso_pkg::dfso_freq_t speed_agree_width, zero_speed_threshold,
    input dfso_pkg::dfso_freq_t minimum_output_frequency // v/f thr
);
    import dfso_pkg::*;
    logic [16:0] f, w, lv;
    logic [11:0] fs;
    logic on, run, zb, rb, ub, live, up1, dn1, up2, dn2;
    // band and hysteresis conditions on magnitudes
    assign {f, w, lv} = {1'b0, out_freq, 1'b0, speed_agree_width,
                         1'b0, speed_agree_level};
    // an unused code stands in while reset is sampled low, so no check
    // starts on the edge at which the design is being reset
    assign fs = rst_n ? output_function_select : 12'hfff;
    assign on = multifunction_output;
    assign run = run_cmd | volt_out;
    assign zb = out_freq < (control_method_select == CM_VECTOR ?
                zero_speed_threshold : minimum_output_frequency);
    assign rb = f <= freq_ref + w && f + w >= freq_ref;
    assign ub = rb && f <= lv + w && f + w >= lv;
    assign live = detection_during_stop_select | volt_out;
    assign up1 = fs == FN_DET1 && live && f > lv + w;
    assign dn1 = fs == FN_DET1 && live && f <= lv;
    assign up2 = fs == FN_DET2 && live && f > lv;
    assign dn2 = fs == FN_DET2 && live && (f + w <= lv || f == 0);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_drop; up1 [*2]; endsequence
    sequence s_set; up2 [*2]; endsequence
    a_run_state: assert property (fs == FN_RUN |=> on == $past(run))
        else $error("run state");
    a_zero_speed: assert property (fs == FN_ZERO |=> on == $past(zb))
        else $error("zero speed");
    a_speed_agree: assert property (fs == FN_AGREE |=> on == $past(rb))
        else $error("speed agree");
    a_user_agree: assert property (fs == FN_USER |=> on == $past(ub))
        else $error("user agree");
    a_det1_drop: assert property (s_drop |=> !on) else $error("det1 drop");
    a_det1_back: assert property (dn1 [*2] |=> on) else $error("det1 back");
    a_det2_set: assert property (s_set |=> on) else $error("det2 set");
    a_det2_clear: assert property (dn2 [*2] |=> !on) else $error("det2 clr");
    a_stop_blank: assert property ((fs == FN_DET1 || fs == FN_DET2) && !live
        |=> !on) else $error("stop blank");
    a_inv_run: assert property (fs == FN_INV_BASE |=> on != $past(run))
        else $error("inverse");
endmodule : dfso_top_properties
bind dfso_top dfso_top_properties i_dfso_top_properties (.*);

// ---- tb/dfso_load.sv ----
// external relay wired to the status terminal
// assumes the terminal is a plain level on mclk
`timescale 1ns/100ps
module dfso_load (
    input logic mclk,     // clock
    input logic terminal, // terminal level
    output logic coil     // relay state, one edge later
);
    // the coil simply follows the terminal
    always_ff @(posedge mclk) coil <= terminal;
endmodule : dfso_load

// ---- tb/tb_dfso_top.sv ----
// self-checking bench for the status output terminal
// assumes dfso_top with a relay model on its terminal
`timescale 1ns/100ps
module tb_dfso_top;
    import dfso_pkg::*;
    logic mclk, rst_n, rc, vo, ds, on, coil, ex, ex_d, l1, l2;
    logic [1:0] cm;
    logic [15:0] lf;
    dfso_fsel_t fs;
    dfso_freq_t fq, fr, mo, zs, lv, w;
    int num_errors, tests_run;
    dfso_fsel_t codes [15] = '{0, 1, 2, 3, 4, 5, 6, 'h100, 'h101, 'h102,
                               'h103, 'h104, 'h105, 'h158, 'h159};
    dfso_top i_dfso_top (.mclk(mclk), .rst_n(rst_n),
        .output_function_select(fs), .control_method_select(cm),
        .run_cmd(rc), .volt_out(vo), .out_freq(fq), .freq_ref(fr),
        .minimum_output_frequency(mo), .zero_speed_threshold(zs),
        .speed_agree_level(lv), .speed_agree_width(w),
        .detection_during_stop_select(ds), .multifunction_output(on));
    dfso_load i_dfso_load (.mclk(mclk), .terminal(on), .coil(coil));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // expected level of a base function from present inputs
    function automatic logic base(input dfso_fsel_t c);
        logic [16:0] f;
        f = fq;
        case (c)
            FN_RUN: return rc | vo;
            FN_ZERO: return fq < (cm == CM_VECTOR ? zs : mo);
            FN_AGREE: return f <= fr + w && f + w >= fr;
            FN_USER: return base(FN_AGREE) && f <= lv + w && f + w >= lv;
            FN_DET1: return l1 && (ds | vo);
            FN_DET2: return l2 && (ds | vo);
            default: return 1'b0;
        endcase
    endfunction : base
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // the relay closes one edge after the terminal
    always @(posedge mclk) ex_d <= ex;
    // reference model, registered like the terminal
    always @(posedge mclk)
        if (!rst_n)
            {ex, l1, l2} <= {RST_OUT, RST_DET1, RST_DET2};
        else
        begin
            ex <= fs >= FN_INV_BASE && fs <= FN_INV_TOP ?
                !base(fs - FN_INV_BASE) : base(fs);
            l1 <= {1'b0, fq} > lv + w ? 1'b0 : fq <= lv ? 1'b1 : l1;
            l2 <= fq > lv ? 1'b1 : ({1'b0, fq} + w <= lv || fq == 0) ?
                1'b0 : l2;
        end
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        num_errors++;
        close_out();
    end
    initial
    begin
        {rst_n, rc, vo, ds, cm, fs, fq, fr, mo, zs, lv, w} = '0;
        lf = 16'h0018;
        repeat (5) @(posedge mclk);
        for (int i = 0; i < 4000; i++)
        begin
            rst_n <= i != 2000;
            lf = lfsr(lf);
            {rc, vo, ds} <= lf[2:0];
            fq <= lf[3] ? fq : {10'h0, lf[9:4]};
            if (i % 32 == 0)
            begin
                fs <= codes[(i / 32) % 15];
                {cm, fr, mo, zs} <= {lf[15:14], 10'h0, lf[13:8],
                                     10'h0, lf[5:0], 10'h0, lf[9:4]};
                {lv, w} <= {10'h0, lf[11:6], 13'h0, lf[14:12]};
            end
            if (i % 512 == 100)
                {fr, w} <= {16'hffff, 16'hffff};
            @(negedge mclk);
            tests_run++;
            if (on !== ex)
            begin
                $display("[FAIL] multifunction_output exp %b got %b", ex, on);
                num_errors++;
            end
            tests_run++;
            if (coil !== ex_d)
            begin
                $display("[FAIL] coil exp %b got %b", ex_d, coil);
                num_errors++;
            end
            @(posedge mclk);
        end
        close_out();
    end
endmodule : tb_dfso_top
